// [src/rtcca_pkg.sv]
// package: register map, field layout, reset values and types of the calendar clock
package rtcca_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TIME = 8'h04;
    localparam logic [7:0] OFF_DATE = 8'h08;
    localparam logic [7:0] OFF_ALM_TIME = 8'h0c;
    localparam logic [7:0] OFF_ALM_DATE = 8'h10;
    localparam logic [7:0] OFF_CAL = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;

    // ==========================================================
    // control field positions and the pm bit of the hour byte
    localparam int CTRL_EN = 0;
    localparam int CTRL_OUT_EN = 1;
    localparam int CTRL_OUT_SEL = 2;
    localparam int CTRL_HOUR24 = 3;
    localparam int CTRL_ALM_EN = 4;
    localparam int CTRL_CLK_SRC = 5;
    localparam int CTRL_MASK_LSB = 8;
    localparam int CTRL_MASK_W = 4;
    localparam int HOUR_PM_BIT = 5;

    // status field positions
    localparam int STAT_ALM = 0;
    localparam int STAT_HALF = 1;

    // ==========================================================
    // reset values
    localparam logic [11:0] CTRL_RST = 12'h009;
    localparam logic [7:0] CAL_RST = 8'h00;

    // ==========================================================
    // time base
    localparam int SRC_HZ = 32768;
    localparam int HALF_TICKS = SRC_HZ / 2;
    localparam int PCLK_HZ = 20000000;

    // ==========================================================
    // alarm repeat mask codes
    typedef enum logic [3:0] {
        RPT_HALF = 4'h0, RPT_SEC = 4'h1, RPT_SEC10 = 4'h2, RPT_MIN = 4'h3,
        RPT_MIN10 = 4'h4, RPT_HOUR = 4'h5, RPT_DAY = 4'h6, RPT_WEEK = 4'h7,
        RPT_MONTH = 4'h8, RPT_YEAR = 4'h9
    } rtcca_rpt_t;

    // bcd time and date words, laid out as their registers
    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rtcca_time_t;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] wday;
    } rtcca_date_t;

    localparam rtcca_time_t TIME_RST = '{hour: 8'h00, min: 8'h00, sec: 8'h00};
    // 2000-01-01 fell on a saturday, weekday 0 is sunday
    localparam rtcca_date_t DATE_RST = '{year: 8'h00, month: 8'h01, day: 8'h01, wday: 8'h06};

endpackage : rtcca_pkg

// [src/rtcca_top.sv]
// calendar clock with alarm, seconds tick output and apb register access
`timescale 1ns/1ps
module rtcca_top
    import rtcca_pkg::*;
#(
    parameter int HALF_CNT = HALF_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic secondary_osc_clock,
    input wire logic timer_clock_input,
    input wire logic master_clear_pin_n,
    output logic rtc_out,
    output logic rtc_out_oe
);

    // ==========================================================
    // bcd helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    function automatic logic [7:0] bcd_wrap(input logic [7:0] v, input logic [7:0] top,
                                            input logic [7:0] low);
        bcd_wrap = (v == top) ? low : bcd_inc(v);
    endfunction : bcd_wrap

    // year 00..99 is a leap year when divisible by four (2000 is one)
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
    endfunction : is_leap

    function automatic logic [7:0] month_len(input logic [7:0] m, input logic leap);
        unique case (m)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction : month_len

    // 24-hour bcd to 12-hour bcd with pm flag in bit 5
    function automatic logic [7:0] to_12h(input logic [7:0] h);
        logic [4:0] b;
        logic [4:0] r;
        b = 5'(h[5:4]) * 5'd10 + 5'(h[3:0]);
        r = (b == 5'd0) ? 5'd12 : ((b > 5'd12) ? b - 5'd12 : b);
        to_12h = {2'b00, (b > 5'd11), (r > 5'd9), (r > 5'd9) ? r[3:0] - 4'ha : r[3:0]};
    endfunction : to_12h

    // ==========================================================
    // registers
    logic [11:0] ctrl_q;
    logic [7:0] cal_q;
    rtcca_time_t time_q;
    rtcca_date_t date_q;
    rtcca_time_t alm_time_q;
    rtcca_date_t alm_date_q;
    logic half_q;
    logic alm_flag_q;
    logic alm_tog_q;
    logic step_q;
    logic [14:0] pre_q;
    logic src_prev_q;
    logic master_clear_pin_q;

    logic wr_en;
    logic hit;
    logic src_sel;
    logic src_edge;
    logic step;
    logic minute_start;
    logic [14:0] pre_top;
    logic [3:0] rpt;
    logic mapped;

    assign rpt = ctrl_q[CTRL_MASK_LSB +: CTRL_MASK_W];

    // ==========================================================
    // apb slave: zero wait states, read data captured in setup
    always_comb begin
        unique case (paddr)
            OFF_CTRL, OFF_TIME, OFF_DATE, OFF_ALM_TIME,
            OFF_ALM_DATE, OFF_CAL, OFF_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                OFF_CTRL: prdata <= {20'h00000, ctrl_q};
                OFF_TIME: prdata <= {8'h00, ctrl_q[CTRL_HOUR24] ? time_q.hour
                                     : to_12h(time_q.hour), time_q.min, time_q.sec};
                OFF_DATE: prdata <= date_q;
                OFF_ALM_TIME: prdata <= {8'h00, alm_time_q};
                OFF_ALM_DATE: prdata <= alm_date_q;
                OFF_CAL: prdata <= {24'h000000, cal_q};
                OFF_STAT: prdata <= {30'h0, half_q, alm_flag_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // control and calibration; master clear drops pin and alarm enables only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_clear_pin_q <= 1'b0;
        end else begin
            master_clear_pin_q <= ~master_clear_pin_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            cal_q <= CAL_RST;
        end else if (master_clear_pin_q) begin
            // enable, source and calibration survive master clear
            ctrl_q[CTRL_OUT_EN] <= 1'b0;
            ctrl_q[CTRL_ALM_EN] <= 1'b0;
        end else if (wr_en && paddr == OFF_CTRL) begin
            ctrl_q <= pwdata[11:0];
        end else if (wr_en && paddr == OFF_CAL) begin
            cal_q <= pwdata[7:0];
        end
    end

    // ==========================================================
    // time base: count rising edges of the 32.768 kHz source
    // source select
    assign src_sel = ctrl_q[CTRL_CLK_SRC] ? timer_clock_input : secondary_osc_clock;
    assign src_edge = src_sel & ~src_prev_q;
    assign minute_start = (time_q.sec == 8'h00) && !half_q;
    // first half second of each minute is shortened or stretched by cal
    assign pre_top = minute_start ? 15'(HALF_CNT - 1 - int'(signed'(cal_q)))
                                  : 15'(HALF_CNT - 1);
    assign step = ctrl_q[CTRL_EN] & src_edge & (pre_q >= pre_top);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_q <= 1'b0;
            pre_q <= 15'h0000;
        end else begin
            src_prev_q <= src_sel;
            if (step) begin
                pre_q <= 15'h0000;
            end else if (ctrl_q[CTRL_EN] && src_edge) begin
                pre_q <= pre_q + 15'h0001;
            end
        end
    end

    // ==========================================================
    // half-second counting chain, bcd throughout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_q <= 1'b0;
            time_q <= TIME_RST;
        end else if (wr_en && paddr == OFF_TIME) begin
            half_q <= 1'b0;
            time_q <= pwdata[23:0];
        end else if (step) begin
            half_q <= ~half_q;
            if (half_q) begin
                time_q.sec <= bcd_wrap(time_q.sec, 8'h59, 8'h00);
                if (time_q.sec == 8'h59) begin
                    time_q.min <= bcd_wrap(time_q.min, 8'h59, 8'h00);
                    if (time_q.min == 8'h59) begin
                        time_q.hour <= bcd_wrap(time_q.hour, 8'h23, 8'h00);
                    end
                end
            end
        end
    end

    // calendar with leap years in hardware
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            date_q <= DATE_RST;
        end else if (wr_en && paddr == OFF_DATE) begin
            date_q <= pwdata;
        end else if (step && half_q
                     && time_q == rtcca_time_t'{hour: 8'h23, min: 8'h59, sec: 8'h59}) begin
            date_q.wday <= bcd_wrap(date_q.wday, 8'h06, 8'h00);
            date_q.day <= bcd_wrap(date_q.day, month_len(date_q.month, is_leap(date_q.year)),
                                   8'h01);
            if (date_q.day == month_len(date_q.month, is_leap(date_q.year))) begin
                date_q.month <= bcd_wrap(date_q.month, 8'h12, 8'h01);
                if (date_q.month == 8'h12) begin
                    // 2099 wraps to 2000
                    date_q.year <= bcd_wrap(date_q.year, 8'h99, 8'h00);
                end
            end
        end
    end

    // ==========================================================
    // alarm: compared one cycle after each step, on the new time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alm_time_q <= TIME_RST;
            alm_date_q <= DATE_RST;
        end else if (wr_en && paddr == OFF_ALM_TIME) begin
            alm_time_q <= pwdata[23:0];
        end else if (wr_en && paddr == OFF_ALM_DATE) begin
            alm_date_q <= pwdata;
        end
    end

    always_comb begin
        unique case (rtcca_rpt_t'(rpt))
            // half second, second, ten seconds, minute
            RPT_HALF: hit = 1'b1;
            RPT_SEC: hit = !half_q;
            RPT_SEC10: hit = !half_q && time_q.sec[3:0] == alm_time_q.sec[3:0];
            RPT_MIN: hit = !half_q && time_q.sec == alm_time_q.sec;
            RPT_MIN10: hit = !half_q && time_q.sec == alm_time_q.sec
                             && time_q.min[3:0] == alm_time_q.min[3:0];
            RPT_HOUR: hit = !half_q && time_q[15:0] == alm_time_q[15:0];
            RPT_DAY: hit = !half_q && time_q == alm_time_q;
            // week, month, year; a feb 29 year alarm only meets leap years
            RPT_WEEK: hit = !half_q && time_q == alm_time_q && date_q.wday == alm_date_q.wday;
            RPT_MONTH: hit = !half_q && time_q == alm_time_q && date_q.day == alm_date_q.day;
            RPT_YEAR: hit = !half_q && time_q == alm_time_q
                            && date_q.day == alm_date_q.day && date_q.month == alm_date_q.month;
            // codes above 1001 never fire
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= 1'b0;
        end else begin
            step_q <= step;
        end
    end

    // sticky flag: a new alarm wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alm_flag_q <= 1'b0;
            alm_tog_q <= 1'b0;
        end else if (step_q && hit && ctrl_q[CTRL_ALM_EN]) begin
            alm_flag_q <= 1'b1;
            alm_tog_q <= ~alm_tog_q;
        end else if (master_clear_pin_q) begin
            alm_flag_q <= 1'b0;
        end else if (wr_en && paddr == OFF_STAT && pwdata[STAT_ALM]) begin
            alm_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // output pin: toggles per alarm, or half_q as a 1 Hz square tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_out <= 1'b0;
            rtc_out_oe <= 1'b0;
        end else begin
            // alarm or seconds tick onto the pin
            rtc_out <= ctrl_q[CTRL_OUT_SEL] ? half_q : alm_tog_q;
            rtc_out_oe <= ctrl_q[CTRL_OUT_EN];
        end
    end

endmodule : rtcca_top

// [tb/rtcca_src_model.sv]
// time-base source model: two free-running clocks synchronous to pclk
`timescale 1ns/1ps
module rtcca_src_model (
    input wire logic pclk,
    output logic osc_a,
    output logic osc_b
);
    logic [2:0] div_q = 3'h0;
    // ==========
    // sources run regardless of any reset
    always @(posedge pclk) begin
        div_q <= div_q + 3'h1;
    end
    // fast source for the oscillator, half rate for the timer input
    assign osc_a = div_q[1];
    assign osc_b = div_q[2];
endmodule : rtcca_src_model

// [tb/rtcca_checker.sv]
// checker: port-level properties of the calendar clock
`timescale 1ns/1ps
module rtcca_checker
    import rtcca_pkg::*;
#(
    parameter int HALF_CNT = HALF_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic master_clear_pin_n,
    input wire logic rtc_out,
    input wire logic rtc_out_oe
);
    logic acc;
    logic hole;
    assign acc = psel && penable;
    assign hole = (paddr > OFF_STAT) || (paddr[1:0] != 2'b00);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========
    // bus answer
    a_ready_high: assert property (pready) else $error("ready low");
    a_err_match: assert property (pslverr == (acc && hole)) else $error("bad slverr");
    a_hole_zero: assert property (psel && !penable && hole |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved");
    a_time_bcd: assert property (psel && !penable && paddr == OFF_TIME |=>
        prdata[31:24] == 8'h00 && prdata[7:4] < 4'h6 && prdata[3:0] < 4'ha)
        else $error("time word not bcd");
    a_stat_zero: assert property (psel && !penable && paddr == OFF_STAT |=>
        prdata[31:2] == 30'h0) else $error("status spare bits set");
    // ==========
    // output pin
    // clear flop lags the pin by one cycle, so the pin must be high before the write too
    a_oe_follow: assert property (master_clear_pin_n ##1
        acc && pwrite && paddr == OFF_CTRL && master_clear_pin_n ##1 master_clear_pin_n |=>
        rtc_out_oe == $past(pwdata[CTRL_OUT_EN], 2)) else $error("oe not ctrl");
    // pin flop, control bit and output flop: three cycles from pin to enable
    a_clear_oe: assert property (!master_clear_pin_n [*3] |=> !rtc_out_oe)
        else $error("oe kept in clear");
    c_hole: cover property (acc && hole);
    c_pin: cover property ($changed(rtc_out));
    c_clear: cover property (!master_clear_pin_n [*2]);
endmodule : rtcca_checker

bind rtcca_top rtcca_checker #(.HALF_CNT(HALF_CNT)) rtcca_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_clear_pin_n(master_clear_pin_n),
    .rtc_out(rtc_out), .rtc_out_oe(rtc_out_oe));

// [tb/rtcca_top_test.sv]
// testbench: apb-driven scenarios for the calendar clock
`timescale 1ns/1ps
module rtcca_top_test;
    import rtcca_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic master_clear_pin_n = 1'b1, pready, pslverr, e, rtc_out, rtc_out_oe, osc_a, osc_b;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, k, t0, cyc = 32'h0;
    logic [31:0] d_in[3] = '{32'h24022803, 32'h23022802, 32'h19123102};
    logic [31:0] d_out[3] = '{32'h24022904, 32'h23030103, 32'h20010103};
    logic [7:0] h_in[4] = '{8'h13, 8'h00, 8'h12, 8'h09};
    logic [7:0] h_out[4] = '{8'h21, 8'h12, 8'h32, 8'h09};
    int fail_count = 0, num_checks = 0, lo;
    rtcca_top #(.HALF_CNT(4)) rtcca_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .secondary_osc_clock(osc_a),
        .timer_clock_input(osc_b), .master_clear_pin_n(master_clear_pin_n),
        .rtc_out(rtc_out), .rtc_out_oe(rtc_out_oe));
    rtcca_src_model rtcca_src_model_i (.pclk(pclk), .osc_a(osc_a), .osc_b(osc_b));
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 32'h1;
    // ==========
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input logic [31:0] v, input int l, input int h);
        chk((v >= l && v <= h) ? l : v, l);
    endtask : rng
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) fail_count++;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask : rd
    task automatic wait_chg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        q = v;
        while ((q & m) === v && n < 200) begin
            apb(1'b0, a, 32'h0);
            n++;
        end
        if (n >= 200) fail_count++;
    endtask : wait_chg
    task automatic cnt_tog(input int c);
        logic p;
        p = rtc_out;
        k = 32'h0;
        repeat (c) begin
            @(posedge pclk);
            if (rtc_out !== p) k++;
            p = rtc_out;
        end
    endtask : cnt_tog
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // ==========
    // watchdog, far above the expected run length
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL, 32'hffffffff, 32'h9);
        rd(OFF_TIME, 32'hffffffff, 32'h0);
        rd(OFF_DATE, 32'hffffffff, 32'h00010106);
        rd(OFF_CAL, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({q[30:0], e}, 32'h1);
        // rollover through leap day, month end and year end
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFF_DATE, d_in[i]);
            apb(1'b1, OFF_TIME, 32'h235959);
            wait_chg(OFF_TIME, 32'hff0000, 32'h230000);
            chk(q, 32'h0);
            rd(OFF_DATE, 32'hffffffff, d_out[i]);
        end
        apb(1'b1, OFF_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_TIME, {8'h0, h_in[i], 16'h3000});
            rd(OFF_TIME, 32'hffff00, {8'h0, h_out[i], 8'h30, 8'h0});
        end
        // every repeat code against alarm at 00:00:07
        apb(1'b1, OFF_ALM_TIME, 32'h7);
        apb(1'b1, OFF_ALM_DATE, 32'h24022904);
        // calendar must match the alarm date so week, month and year codes can fire
        apb(1'b1, OFF_DATE, 32'h24022904);
        for (int m = 0; m < 11; m++) begin
            apb(1'b1, OFF_CTRL, {20'h0, m[3:0], 8'h1b});
            apb(1'b1, OFF_TIME, 32'h5);
            cnt_tog(96);
            lo = (m == 0) ? 5 : (m == 1) ? 2 : (m == 10) ? 0 : 1;
            rng(k, lo, lo + ((m < 2) ? 2 : 0));
        end
        rd(OFF_STAT, 32'h1, 32'h1);
        apb(1'b1, OFF_STAT, 32'h1);
        rd(OFF_STAT, 32'h1, 32'h0);
        // tick output from each source
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, OFF_CTRL, s ? 32'h2f : 32'hf);
            cnt_tog(128);
            rng(k, s ? 3 : 7, s ? 5 : 9);
        end
        // time must advance while master clear is held
        apb(1'b1, OFF_CTRL, 32'hb);
        apb(1'b1, OFF_TIME, 32'h0);
        master_clear_pin_n <= 1'b0;
        wait_chg(OFF_TIME, 32'hff, 32'h0);
        master_clear_pin_n <= 1'b1;
        rd(OFF_CTRL, 32'h3f, 32'h9);
        // first half second of a minute shortened by calibration
        for (int c = 0; c < 2; c++) begin
            apb(1'b1, OFF_CAL, c ? 32'h2 : 32'h0);
            apb(1'b1, OFF_TIME, 32'h59);
            wait_chg(OFF_TIME, 32'hff, 32'h59);
            t0 = cyc;
            wait_chg(OFF_TIME, 32'hff, 32'h0);
            rng(cyc - t0, c ? 21 : 29, c ? 27 : 35);
        end
        wrap_up();
    end
endmodule : rtcca_top_test
